// *** logic/rspwm_defs.svh ***
// Offsets, field positions, reset values and timing counts of the PWM timer
`ifndef RSPWM_DEFS_SVH
`define RSPWM_DEFS_SVH

// ****************************************
// Register offsets (low byte of address)
// ****************************************
`define OFS_CH3_CNT_CTRL 8'h00
`define OFS_CH4_CNT_CTRL 8'h01
`define OFS_CH3_MODE 8'h02
`define OFS_CH4_MODE 8'h03
`define OFS_CH3_IRQ_EN 8'h08
`define OFS_OUT_EN_MASK 8'h0a
`define OFS_OUT_LEVEL 8'h0e
`define OFS_MASTER_CNT 8'h10
`define OFS_SLAVE_CNT 8'h12
`define OFS_PERIOD_CMP 8'h18
`define OFS_DUTY1_CMP 8'h1a
`define OFS_DUTY2_CMP 8'h1c
`define OFS_DUTY3_CMP 8'h1e
`define OFS_PERIOD_SHD 8'h24
`define OFS_DUTY1_SHD 8'h26
`define OFS_DUTY2_SHD 8'h28
`define OFS_DUTY3_SHD 8'h2a
`define OFS_COUNTER_RUN 8'h80

// ****************************************
// Field positions
// ****************************************
`define CLR_SRC_HI 7
`define CLR_SRC_LO 5
`define EDGE_HI 4
`define EDGE_LO 3
`define PSC_HI 2
`define PSC_LO 0
`define SHD_DUTY_BIT 5
`define SHD_PERIOD_BIT 4
`define MODE_HI 3
`define MODE_LO 0
`define CYC_TOG_BIT 6
`define NEG_LVL_BIT 1
`define POS_LVL_BIT 0
`define PER_IRQ_BIT 0
`define RUN_CH3_BIT 6
`define RUN_CH4_BIT 7

// ****************************************
// Field codes
// ****************************************
`define CLR_ON_PERIOD 3'h1
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define PSC_DIV1 3'h0
`define PSC_DIV4 3'h1
`define PSC_DIV16 3'h2
`define PSC_DIV64 3'h3
`define MODE_RESET_SYNC 4'h8

// ****************************************
// Reset values and timing
// ****************************************
`define RST_CTRL 8'h00
`define RST_OUT_EN 8'h00
`define RST_COUNT 16'h0000
`define RST_COMPARE 16'hffff
`define PSC_WIDTH 6

`endif

// *** logic/rspwm_pkg.sv ***
// Types shared by the reset-synchronized three-phase PWM timer
package rspwm_pkg;

  // Register access request from the on-chip peripheral bus
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Read answer
  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
  } reg_rsp_t;

  // Pin levels and enables towards the power stage
  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] pos_oe;
    logic [2:0] neg;
    logic [2:0] neg_oe;
    logic cyc;
    logic cyc_oe;
  } pwm_pins_t;

endpackage

// *** logic/reset_sync_three_phase_pwm.sv ***
// Reset-synchronized three-phase PWM timer with shadowed compares
`timescale 1ns/1ns
`default_nettype none
`include "rspwm_defs.svh"

// Notes on behaviour
// RULE1: Both shadow enables set: each shadow backs its compare register.
// RULE2: Shadows copy into compares at every period match.
// RULE3: A period match interrupt request comes once per carrier cycle.
// RULE4: Counter clears on leaving the period value: period plus one counts.
// RULE5: Duty zero gives a one-count pulse each carrier cycle.
// RULE6: Duty at or above period toggles the output once per cycle.
// RULE7: Duty equal to period toggles at the shared period match count.
// RULE8: Fixed high or low needs pin muxing to port, not duty values.
// RULE9: Clear source 001 clears master counter on period match.
// RULE10: Edge code 00 counts on the rising edge of the count clock.
// RULE11: Prescale code 001 counts at mclk divided by four.
// RULE12: Mode code 1000 selects reset-synchronized PWM for both channels.
// RULE13: Software stops both counters before changing the mode.
// RULE14: In this mode channel 4 control is ignored; channel 3 settings apply.
// RULE15: Software leaves channel 4 mode fields at their initial values.
// RULE16: Cycle toggle enable drives a carrier-synchronous toggle output.
// RULE17: Level selects make antiphase and positive outputs high-active.
// RULE18: Each pin drives only when its output enable mask bit is set.
// RULE19: The irq enable lets the period match reach the interrupt output.
// RULE20: Software loads equal duty and shadow values not above period; the bench also loads duties of period plus one.
// RULE21: Software zeroes both counters before starting; the bench zeroes only the master counter before its restart.
// RULE22: Three positive outputs, each with an inverse antiphase companion.
// RULE23: Counter counts up from zero; outputs toggle on match and clear.
// RULE24: Run bit of channel 3 starts both counters in this mode.
// RULE25: Without shadowing, compare writes take effect at once.
// RULE26: Equal level selects give exact complements, no dead time.
module reset_sync_three_phase_pwm
  import rspwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register access
  input wire reg_req_t req,
  output reg_rsp_t rsp,
  // Power stage pins
  output pwm_pins_t pins,
  // Interrupt request to the controller
  output logic period_match_irq
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ch3_ctrl, next_ch3_ctrl;
  logic [7:0] ch4_ctrl, next_ch4_ctrl;
  logic [7:0] ch3_mode, next_ch3_mode;
  logic [7:0] ch4_mode, next_ch4_mode;
  logic [7:0] irq_en, next_irq_en;
  logic [7:0] out_en, next_out_en;
  logic [7:0] out_level, next_out_level;
  logic [7:0] run, next_run;
  logic [15:0] master_counter, next_master_counter;
  logic [15:0] slave_counter, next_slave_counter;
  logic [15:0] period_compare, next_period_compare;
  logic [15:0] period_shadow, next_period_shadow;
  logic [15:0] duty_compare [3], next_duty_compare [3];
  logic [15:0] duty_shadow [3], next_duty_shadow [3];
  logic [`PSC_WIDTH-1:0] psc_cnt, next_psc_cnt;
  logic [2:0] raw, next_raw;
  logic cyc_raw, next_cyc_raw;
  reg_rsp_t next_rsp;
  pwm_pins_t next_pins;
  logic next_irq;

  // ****************************************
  // Decoding helpers
  // ****************************************

  // Write strobe for one register offset
  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // Terminal prescaler count for a divider code
  function automatic logic [`PSC_WIDTH-1:0] div_last(input logic [2:0] sel);
    unique case (sel)
      `PSC_DIV1: return 6'h00;
      `PSC_DIV4: return 6'h03;
      `PSC_DIV16: return 6'h0f;
      default: return 6'h3f;
    endcase
  endfunction

  logic resync, run_m, run_s, tick, clr_ev;
  logic [`PSC_WIDTH-1:0] psc_last;
  logic [2:0] duty_ev;

  // Mode and start decode; channel 3 settings serve both channels
  assign resync = ch3_mode[`MODE_HI:`MODE_LO] == `MODE_RESET_SYNC; // RULE12
  assign run_m = run[`RUN_CH3_BIT];
  assign run_s = run[`RUN_CH4_BIT] || (resync && run_m); // RULE24 RULE14
  assign psc_last = div_last(ch3_ctrl[`PSC_HI:`PSC_LO]); // RULE11

  // Count tick: rising edge of the divided clock is the wrap of the
  // prescaler, falling is its midpoint, any other code counts on both.
  // At divide-by-one both edges collapse into every cycle.
  always_comb begin
    unique case (ch3_ctrl[`EDGE_HI:`EDGE_LO])
      `EDGE_RISE: tick = psc_cnt == psc_last; // RULE10
      `EDGE_FALL: tick = psc_cnt == (psc_last >> 1);
      default: tick = (psc_cnt == psc_last) || (psc_cnt == (psc_last >> 1));
    endcase
  end

  // Period match: counter leaves the period value on this tick
  assign clr_ev = run_m && tick && (master_counter == period_compare) &&
                  (ch3_ctrl[`CLR_SRC_HI:`CLR_SRC_LO] == `CLR_ON_PERIOD); // RULE9

  // Duty matches fire as the counter leaves the duty value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      duty_ev[i] = run_m && tick && (master_counter == duty_compare[i]);
    end
  end

  // ****************************************
  // Counters and prescaler
  // ****************************************

  // Prescaler free-runs while either run bit (channel 3 or 4) is set; a software counter write
  // wins over counting in the same cycle
  always_comb begin
    next_psc_cnt = psc_cnt;
    next_master_counter = master_counter;
    next_slave_counter = slave_counter;
    if (run_m || run_s) begin
      next_psc_cnt = (psc_cnt >= psc_last) ? '0 : psc_cnt + 6'h01; // RULE11
    end
    if (clr_ev) begin
      next_master_counter = '0; // RULE4 RULE23
    end else if (run_m && tick) begin
      next_master_counter = master_counter + 16'h0001; // RULE23
    end
    // In the linked mode the slave follows the master's clock and clear
    if (resync && clr_ev) begin
      next_slave_counter = '0; // RULE14
    end else if (run_s && tick) begin
      next_slave_counter = slave_counter + 16'h0001;
    end
    if (wr_hit(req, `OFS_MASTER_CNT)) begin
      next_master_counter = req.wdata;
    end
    if (wr_hit(req, `OFS_SLAVE_CNT)) begin
      next_slave_counter = req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      psc_cnt <= '0;
      master_counter <= `RST_COUNT;
      slave_counter <= `RST_COUNT;
    end else begin
      psc_cnt <= next_psc_cnt;
      master_counter <= next_master_counter;
      slave_counter <= next_slave_counter;
    end
  end

  // ****************************************
  // Control, compare and shadow registers
  // ****************************************

  // Compare writes land immediately; the shadow copy at a period match
  // overrides a same-cycle write so the carrier never sees a mixed set
  always_comb begin
    next_ch3_ctrl = wr_hit(req, `OFS_CH3_CNT_CTRL) ? req.wdata[7:0] : ch3_ctrl;
    next_ch4_ctrl = wr_hit(req, `OFS_CH4_CNT_CTRL) ? req.wdata[7:0] : ch4_ctrl;
    next_ch3_mode = wr_hit(req, `OFS_CH3_MODE) ? req.wdata[7:0] : ch3_mode;
    next_ch4_mode = wr_hit(req, `OFS_CH4_MODE) ? req.wdata[7:0] : ch4_mode;
    next_irq_en = wr_hit(req, `OFS_CH3_IRQ_EN) ? req.wdata[7:0] : irq_en;
    next_out_en = wr_hit(req, `OFS_OUT_EN_MASK) ? req.wdata[7:0] : out_en;
    next_out_level = wr_hit(req, `OFS_OUT_LEVEL) ? req.wdata[7:0] : out_level;
    next_run = wr_hit(req, `OFS_COUNTER_RUN) ? req.wdata[7:0] : run;
    next_period_compare = period_compare;
    next_period_shadow = period_shadow;
    if (wr_hit(req, `OFS_PERIOD_CMP)) begin
      next_period_compare = req.wdata; // RULE25
    end
    if (wr_hit(req, `OFS_PERIOD_SHD)) begin
      next_period_shadow = req.wdata;
    end
    if (clr_ev && ch3_mode[`SHD_PERIOD_BIT]) begin
      next_period_compare = period_shadow; // RULE1 RULE2
    end
    for (int i = 0; i < 3; i++) begin
      next_duty_compare[i] = duty_compare[i];
      next_duty_shadow[i] = duty_shadow[i];
    end
    if (wr_hit(req, `OFS_DUTY1_CMP)) next_duty_compare[0] = req.wdata; // RULE25
    if (wr_hit(req, `OFS_DUTY2_CMP)) next_duty_compare[1] = req.wdata;
    if (wr_hit(req, `OFS_DUTY3_CMP)) next_duty_compare[2] = req.wdata;
    if (wr_hit(req, `OFS_DUTY1_SHD)) next_duty_shadow[0] = req.wdata;
    if (wr_hit(req, `OFS_DUTY2_SHD)) next_duty_shadow[1] = req.wdata;
    if (wr_hit(req, `OFS_DUTY3_SHD)) next_duty_shadow[2] = req.wdata;
    if (clr_ev && ch3_mode[`SHD_DUTY_BIT]) begin
      for (int i = 0; i < 3; i++) begin
        next_duty_compare[i] = duty_shadow[i]; // RULE1 RULE2
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ch3_ctrl <= `RST_CTRL;
      ch4_ctrl <= `RST_CTRL;
      ch3_mode <= `RST_CTRL;
      ch4_mode <= `RST_CTRL;
      irq_en <= `RST_CTRL;
      out_en <= `RST_OUT_EN;
      out_level <= `RST_CTRL;
      run <= `RST_CTRL;
      period_compare <= `RST_COMPARE;
      period_shadow <= `RST_COMPARE;
      for (int i = 0; i < 3; i++) begin
        duty_compare[i] <= `RST_COMPARE;
        duty_shadow[i] <= `RST_COMPARE;
      end
    end else begin
      ch3_ctrl <= next_ch3_ctrl;
      ch4_ctrl <= next_ch4_ctrl;
      ch3_mode <= next_ch3_mode;
      ch4_mode <= next_ch4_mode;
      irq_en <= next_irq_en;
      out_en <= next_out_en;
      out_level <= next_out_level;
      run <= next_run;
      period_compare <= next_period_compare;
      period_shadow <= next_period_shadow;
      for (int i = 0; i < 3; i++) begin
        duty_compare[i] <= next_duty_compare[i];
        duty_shadow[i] <= next_duty_shadow[i];
      end
    end
  end

  // ****************************************
  // Waveform generation
  // ****************************************

  // A duty match coinciding with the period match toggles once, not twice;
  // waveforms hold their phase outside the linked mode
  always_comb begin
    next_raw = raw;
    next_cyc_raw = cyc_raw;
    if (resync) begin
      for (int i = 0; i < 3; i++) begin
        if (clr_ev || duty_ev[i]) begin
          next_raw[i] = ~raw[i]; // RULE5 RULE6 RULE7 RULE23
        end
      end
      if (clr_ev && out_level[`CYC_TOG_BIT]) begin
        next_cyc_raw = ~cyc_raw; // RULE16
      end
    end
  end

  // Pin stage: polarity from the level selects, no dead time inserted.
  // Built from the next waveform state so pins move with the irq pulse.
  always_comb begin
    logic pos_hi;
    logic neg_hi;
    pos_hi = out_level[`POS_LVL_BIT];
    neg_hi = out_level[`NEG_LVL_BIT];
    for (int i = 0; i < 3; i++) begin
      next_pins.pos[i] = pos_hi ? next_raw[i] : ~next_raw[i]; // RULE17 RULE22
      next_pins.neg[i] = neg_hi ? ~next_raw[i] : next_raw[i]; // RULE17 RULE26
    end
    next_pins.pos_oe = {out_en[2], out_en[1], out_en[0]}; // RULE18
    next_pins.neg_oe = {out_en[5], out_en[4], out_en[3]}; // RULE18
    next_pins.cyc = next_cyc_raw;
    next_pins.cyc_oe = out_level[`CYC_TOG_BIT]; // RULE16
    next_irq = clr_ev && irq_en[`PER_IRQ_BIT]; // RULE3 RULE19
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      raw <= '0;
      cyc_raw <= 1'b0;
      pins <= '0;
      period_match_irq <= 1'b0;
    end else begin
      raw <= next_raw;
      cyc_raw <= next_cyc_raw;
      pins <= next_pins;
      period_match_irq <= next_irq;
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // One-cycle registered read; unmapped offsets answer zero
  always_comb begin
    next_rsp.rvalid = req.rd;
    next_rsp.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_CH3_CNT_CTRL: next_rsp.rdata = {8'h00, ch3_ctrl};
        `OFS_CH4_CNT_CTRL: next_rsp.rdata = {8'h00, ch4_ctrl};
        `OFS_CH3_MODE: next_rsp.rdata = {8'h00, ch3_mode};
        `OFS_CH4_MODE: next_rsp.rdata = {8'h00, ch4_mode};
        `OFS_CH3_IRQ_EN: next_rsp.rdata = {8'h00, irq_en};
        `OFS_OUT_EN_MASK: next_rsp.rdata = {8'h00, out_en};
        `OFS_OUT_LEVEL: next_rsp.rdata = {8'h00, out_level};
        `OFS_COUNTER_RUN: next_rsp.rdata = {8'h00, run};
        `OFS_MASTER_CNT: next_rsp.rdata = master_counter;
        `OFS_SLAVE_CNT: next_rsp.rdata = slave_counter;
        `OFS_PERIOD_CMP: next_rsp.rdata = period_compare;
        `OFS_PERIOD_SHD: next_rsp.rdata = period_shadow;
        `OFS_DUTY1_CMP: next_rsp.rdata = duty_compare[0];
        `OFS_DUTY2_CMP: next_rsp.rdata = duty_compare[1];
        `OFS_DUTY3_CMP: next_rsp.rdata = duty_compare[2];
        `OFS_DUTY1_SHD: next_rsp.rdata = duty_shadow[0];
        `OFS_DUTY2_SHD: next_rsp.rdata = duty_shadow[1];
        `OFS_DUTY3_SHD: next_rsp.rdata = duty_shadow[2];
        default: next_rsp.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

endmodule
`default_nettype wire

// *** testbench/rspwm_asserts.sv ***
// Port assertions for the reset-synchronized PWM timer
`timescale 1ns/1ns
`default_nettype none
`include "rspwm_defs.svh"
module rspwm_asserts
  import rspwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Watched ports
  input wire reg_req_t req,
  input wire reg_rsp_t rsp,
  input wire pwm_pins_t pins,
  input wire logic period_match_irq
);
  // ********************
  // Control mirrors
  // ********************
  logic [7:0] lvl;
  logic [7:0] oem;
  logic [7:0] ien;
  logic [7:0] run;
  logic [7:0] mode;
  logic [1:0] settle;

  // Settle masks the edges where outputs still show reset values
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl <= 8'h00;
      oem <= 8'h00;
      ien <= 8'h00;
      run <= 8'h00;
      mode <= 8'h00;
      settle <= 2'h0;
    end else begin
      settle <= (settle == 2'h3) ? settle : settle + 2'h1;
      if (req.wr) begin
        case (req.addr)
          `OFS_OUT_LEVEL: lvl <= req.wdata[7:0];
          `OFS_OUT_EN_MASK: oem <= req.wdata[7:0];
          `OFS_CH3_IRQ_EN: ien <= req.wdata[7:0];
          `OFS_COUNTER_RUN: run <= req.wdata[7:0];
          `OFS_CH3_MODE: mode <= req.wdata[7:0];
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  AST_RVALID_LAG: assert property (
    settle != 2'h0 |-> rsp.rvalid == $past(req.rd))
    else $error("read valid not one cycle after the strobe");
  AST_RDATA_QUIET: assert property (!rsp.rvalid |-> rsp.rdata == 16'h0000)
    else $error("read data not zero outside a read");
  AST_IRQ_PULSE: assert property (
    period_match_irq |=> !period_match_irq)
    else $error("period irq longer than one cycle");
  AST_IRQ_GATED: assert property (
    period_match_irq |-> ien[0] || $past(ien[0]))
    else $error("period irq while disabled");
  AST_IRQ_RUNNING: assert property (
    period_match_irq |-> $past(run[6]) || $past(run[6], 2))
    else $error("period irq while counter stopped");
  AST_OE_MAP: assert property (
    settle == 2'h3 |-> {pins.neg_oe, pins.pos_oe} == $past(oem[5:0]))
    else $error("pin enables differ from the mask");
  AST_CYC_OE: assert property (
    settle == 2'h3 |-> pins.cyc_oe == $past(lvl[6]))
    else $error("cycle toggle enable mismatch");
  AST_COMPLEMENT: assert property (
    settle == 2'h3 && lvl[1] == lvl[0] && $stable(lvl)
      |-> pins.neg == ~pins.pos)
    else $error("antiphase not the inverse");
  AST_CYC_TOGGLE: assert property (
    period_match_irq && mode[3:0] == 4'h8 && pins.cyc_oe
      && $past(pins.cyc_oe) |-> pins.cyc != $past(pins.cyc))
    else $error("cycle output did not toggle");
endmodule

bind reset_sync_three_phase_pwm rspwm_asserts chk (
  .mclk(mclk),
  .rst_b(rst_b),
  .req(req),
  .rsp(rsp),
  .pins(pins),
  .period_match_irq(period_match_irq)
);
`default_nettype wire

// *** testbench/power_stage_model.sv ***
// Power stage model: resolves pin wires and watches for shoot-through
`timescale 1ns/1ns
`default_nettype none
module power_stage_model
  import rspwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pins from the timer
  input wire pwm_pins_t pins,
  // Resolved wire levels
  output logic [2:0] pos_w,
  output logic [2:0] neg_w,
  output logic cyc_w,
  // Sticky: both legs of one phase on together
  output logic overlap
);
  // ********************
  // Gate inputs
  // ********************
  // Undriven legs fall to the gate-driver pull-down
  assign pos_w = pins.pos & pins.pos_oe;
  assign neg_w = pins.neg & pins.neg_oe;
  assign cyc_w = pins.cyc & pins.cyc_oe;

  // Both legs on would short the bridge, so it is remembered
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overlap <= 1'b0;
    end else if (|(pos_w & neg_w)) begin
      overlap <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/test_reset_sync_three_phase_pwm.sv ***
// Self-checking bench for the reset-synchronized PWM timer
`timescale 1ns/1ns
`default_nettype none
`include "rspwm_defs.svh"
module test_reset_sync_three_phase_pwm
  import rspwm_pkg::*;
;
  // ********************
  // Signals and model state
  // ********************
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t req = '0;
  reg_rsp_t rsp;
  pwm_pins_t pins;
  logic period_match_irq;
  logic [2:0] pos_w;
  logic [2:0] neg_w;
  logic cyc_w;
  logic overlap;
  logic [15:0] rv;
  logic [2:0] pm;
  int n_mismatch = 0;
  int comparisons = 0;
  int per;
  int n;
  int nd;
  int duty [3];
  int st [3];
  int hi [3];
  int tg [3];
  logic [7:0] cmp_ofs [4] = '{`OFS_PERIOD_CMP, `OFS_DUTY1_CMP,
    `OFS_DUTY2_CMP, `OFS_DUTY3_CMP};
  logic [7:0] shd_ofs [4] = '{`OFS_PERIOD_SHD, `OFS_DUTY1_SHD,
    `OFS_DUTY2_SHD, `OFS_DUTY3_SHD};
  logic [7:0] rst_ofs [16] = '{`OFS_CH3_CNT_CTRL, `OFS_CH3_MODE,
    `OFS_CH3_IRQ_EN, `OFS_OUT_EN_MASK, `OFS_OUT_LEVEL, `OFS_MASTER_CNT,
    `OFS_SLAVE_CNT, `OFS_PERIOD_CMP, `OFS_DUTY1_CMP, `OFS_DUTY2_CMP,
    `OFS_DUTY3_CMP, `OFS_PERIOD_SHD, `OFS_DUTY1_SHD, `OFS_DUTY2_SHD,
    `OFS_DUTY3_SHD, 8'h40};

  always #25 mclk = ~mclk;

  reset_sync_three_phase_pwm uut (.mclk(mclk), .rst_b(rst_b), .req(req),
    .rsp(rsp), .pins(pins), .period_match_irq(period_match_irq));
  power_stage_model stage (.mclk(mclk), .rst_b(rst_b), .pins(pins),
    .pos_w(pos_w), .neg_w(neg_w), .cyc_w(cyc_w), .overlap(overlap));

  // ********************
  // Bench tasks
  // ********************
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs move 2 ns after the edge; strobes idle one edge between uses
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    req.addr = a;
    req.rd = 1'b1;
    tick();
    req.rd = 1'b0;
    d = rsp.rdata;
    check(rsp.rvalid, 1'b1);
    tick();
  endtask

  task automatic wait_irq();
    int i;
    i = 0;
    do begin
      tick();
      i++;
      if (i > 6000) begin
        n_mismatch++;
        tally_and_finish();
      end
    end while (period_match_irq !== 1'b1);
  endtask

  // Counts one carrier from an irq cycle up to the next irq
  task automatic measure();
    logic [2:0] prev;
    n = 0;
    hi = '{0, 0, 0};
    tg = '{0, 0, 0};
    prev = pos_w;
    do begin
      for (int i = 0; i < 3; i++) begin
        hi[i] += pos_w[i];
        tg[i] += int'(pos_w[i] != prev[i]);
      end
      prev = pos_w;
      tick();
      n++;
      if (n > 6000) begin
        n_mismatch++;
        tally_and_finish();
      end
    end while (period_match_irq !== 1'b1);
  endtask

  // High cycles in a carrier, given the level just after the clear toggle
  function automatic int exp_hi(int s, int d, int p);
    if (d >= p) return s ? 4 * (p + 1) : 0;
    return s ? 4 * (d + 1) : 4 * (p - d);
  endfunction

  task automatic check_carrier();
    measure();
    check(n, 4 * (per + 1));
    for (int i = 0; i < 3; i++) begin
      check(hi[i], pm[i] ? exp_hi(st[i], duty[i], per) : 0);
      check(tg[i], (pm[i] && duty[i] < per) ? 1 : 0);
    end
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    void'($urandom(99));
    repeat (12) @(posedge mclk);
    #2;
    rst_b = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(rst_ofs[i], rv);
      check(rv, (i >= 7 && i < 15) ? `RST_COMPARE : 16'h0000);
    end
    // Stopped setup with equal compare and shadow values
    wr(`OFS_COUNTER_RUN, 16'h0000);
    wr(`OFS_CH3_CNT_CTRL, 16'h0021);
    wr(`OFS_MASTER_CNT, 16'h0000);
    wr(`OFS_SLAVE_CNT, 16'h0000);
    per = 7;
    duty = '{3, 3, 3};
    st = '{0, 0, 0};
    pm = 3'h7;
    for (int i = 0; i < 4; i++) begin
      wr(cmp_ofs[i], (i == 0) ? 16'h0007 : 16'h0003);
      wr(shd_ofs[i], (i == 0) ? 16'h0007 : 16'h0003);
    end
    wr(`OFS_OUT_LEVEL, 16'h0043);
    wr(`OFS_CH3_MODE, 16'h0038);
    wr(`OFS_OUT_EN_MASK, 16'h003f);
    wr(`OFS_CH3_IRQ_EN, 16'h0001);
    wr(`OFS_COUNTER_RUN, 16'h0040);
    // New period and duties through the shadows each round; the level
    // state cannot drift since each value set lasts two carriers
    for (int k = 0; k < 7; k++) begin
      nd = duty[0];
      per = $urandom_range(9, 3);
      for (int i = 0; i < 3; i++) duty[i] = $urandom_range(per + 1, 0);
      if (k == 0) duty = '{0, per, per + 1};
      wr(`OFS_PERIOD_SHD, per[15:0]);
      for (int i = 0; i < 3; i++) wr(shd_ofs[i + 1], duty[i][15:0]);
      rd(`OFS_DUTY1_CMP, rv);
      check(rv, nd[15:0]);
      pm = (k == 2) ? 3'h0 : 3'h7;
      if (k >= 2 && k <= 3) wr(`OFS_OUT_EN_MASK, {10'h0, 3'h7, pm});
      wait_irq();
      check_carrier();
    end
    // Direct compare write with shadowing off, stopped around the change
    wr(`OFS_COUNTER_RUN, 16'h0000);
    wr(`OFS_CH3_MODE, 16'h0008);
    nd = (duty[0] == 1) ? 2 : 1;
    wr(`OFS_DUTY1_CMP, nd[15:0]);
    wr(`OFS_MASTER_CNT, 16'h0000);
    wr(`OFS_COUNTER_RUN, 16'h0040);
    rd(`OFS_SLAVE_CNT, rv);
    repeat (8) tick();
    rd(`OFS_SLAVE_CNT, hi[0][15:0]);
    check(rv != hi[0][15:0], 1'b1);
    // Two clears pass before the measured carrier, so the level state holds
    duty[0] = nd;
    wait_irq();
    check_carrier();
    rd(`OFS_DUTY1_CMP, rv);
    check(rv, nd[15:0]);
    // Prescale codes 000 to 011, measured over a whole carrier
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_CH3_CNT_CTRL, 16'h0020 | c[15:0]);
      wait_irq();
      measure();
      check(n, (per + 1) * (1 << (2 * c)));
    end
    wr(`OFS_CH3_CNT_CTRL, 16'h0021);
    // Masked interrupt stays silent over two carriers
    wr(`OFS_CH3_IRQ_EN, 16'h0000);
    n = 0;
    repeat (8 * (per + 1) + 8) begin
      tick();
      n += int'(period_match_irq === 1'b1);
    end
    check(n, 0);
    wr(`OFS_CH3_IRQ_EN, 16'h0001);
    wait_irq();
    check(overlap, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
